/* hw/rxs_pkg.sv */
// package: register map, field layouts and event carrier for the rx error statistics bank
package rxs_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [15:0] RXS_CRC_ERROR_COUNT_ADDR       = 16'h4000;
    localparam logic [15:0] RXS_ALIGNMENT_ERROR_COUNT_ADDR = 16'h4004;
    localparam logic [15:0] RXS_SYMBOL_ERROR_COUNT_ADDR    = 16'h4008;
    localparam logic [15:0] RXS_RECEIVE_ERROR_COUNT_ADDR   = 16'h400C;
    localparam logic [15:0] RXS_INT_STATUS_ADDR            = 16'h4100;
    localparam logic [15:0] RXS_INT_MASK_ADDR              = 16'h4104;
    localparam logic [15:0] RXS_CONTROL_ADDR               = 16'h4108;

    // ----------------------------------------
    // widths, reset values, limits
    // ----------------------------------------
    localparam int          RXS_CNT_W       = 32;
    localparam int          RXS_NUM_CNT     = 4;
    localparam int          RXS_LEN_W       = 16;
    localparam logic [31:0] RXS_CNT_RESET   = 32'h0000_0000;
    localparam logic [31:0] RXS_CNT_MAX     = 32'hFFFF_FFFF;
    localparam logic [31:0] RXS_CNT_ONE     = 32'h0000_0001;
    localparam logic [15:0] RXS_MIN_FRAME   = 16'h0040;
    localparam logic [31:0] RXS_DATA_ZERO   = 32'h0000_0000;
    localparam logic [3:0]  RXS_MASK_RESET  = 4'h0;
    localparam logic [1:0]  RXS_CTRL_RESET  = 2'h0;

    // ----------------------------------------
    // counter indices (also status / mask bit positions)
    // ----------------------------------------
    localparam int RXS_IDX_CRC   = 0;
    localparam int RXS_IDX_ALIGN = 1;
    localparam int RXS_IDX_SYM   = 2;
    localparam int RXS_IDX_RXERR = 3;

    // control register fields
    localparam int RXS_CTRL_RX_ENABLE = 0;
    localparam int RXS_CTRL_SERDES    = 1;

    // ----------------------------------------
    // link speed encoding
    // ----------------------------------------
    typedef enum logic [1:0] {
        RXS_SPEED_10   = 2'h0,
        RXS_SPEED_100  = 2'h1,
        RXS_SPEED_1000 = 2'h2
    } rxs_speed_t;

    // ----------------------------------------
    // per-frame report from the receive mac path
    // ----------------------------------------
    typedef struct packed {
        logic                 done;         // one-cycle pulse at end of frame
        logic [RXS_LEN_W-1:0] length;       // bytes, destination address through crc
        logic                 filter_pass;  // passed address filtering
        logic                 crc_bad;
        logic                 align_bad;    // non-integer byte length
        logic                 phy_receive_error_flag;
    } rxs_frame_t;

    // ----------------------------------------
    // serdes code-level events
    // ----------------------------------------
    typedef struct packed {
        logic bad_symbol;   // one-cycle pulse per bad symbol
        logic invalid_code; // one-cycle pulse per /V/ code group
    } rxs_serdes_t;

endpackage

/* hw/rxs_stat_bank.sv */
// module: receive error statistics counter bank with apb slave and interrupt
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - every statistics counter is a 32-bit register.
// - unaligned 32-bit counters are reached by 32-bit accesses only.
// - octet counters pair two 32-bit registers into one 64-bit count.
// - reading a counter returns its value then clears it.
// - a 64-bit counter clears only when its upper half is read.
// - counters stick at all-ones until cleared by a read.
// - a frame is received once filtered and stored, host transfer irrelevant.
// - crc errors count filtered frames of 64 bytes or more.
// - crc, alignment, receive error counters hold while reception disabled.
// - alignment errors count filtered non-integer-length frames of 64 bytes plus.
// - alignment errors count only in mii mode at 10 or 100 Mb/s.
// - symbol errors count every bad symbol regardless of frame or link.
// - symbol errors count only in internal serdes mode.
// - receive errors count filtered 64-byte-plus frames flagged by the phy.
// - in serdes mode receive errors count each /V/ code group instead.
module rxs_stat_bank (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // receive mac path
    input  wire rxs_pkg::rxs_frame_t  rx_frame,
    input  wire rxs_pkg::rxs_serdes_t serdes_evt,
    input  wire rxs_pkg::rxs_speed_t  link_speed,
    // interrupt
    output logic                      irq
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire rst_n = rst_sync_r;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic [rxs_pkg::RXS_NUM_CNT-1:0] int_status_r;
    logic [rxs_pkg::RXS_NUM_CNT-1:0] int_mask_r;
    logic [1:0]                      ctrl_r;
    logic [rxs_pkg::RXS_CNT_W-1:0]   cnt_r [rxs_pkg::RXS_NUM_CNT];

    // single-cycle access phase: pready is high in the first access cycle only
    wire apb_access = psel && penable;
    // read captured and cleared at the setup edge, so no event slips between them
    wire apb_rd     = psel && !penable && !pwrite;
    wire apb_wr     = apb_access && pwrite;

    wire sel_crc    = (paddr == rxs_pkg::RXS_CRC_ERROR_COUNT_ADDR);
    wire sel_align  = (paddr == rxs_pkg::RXS_ALIGNMENT_ERROR_COUNT_ADDR);
    wire sel_sym    = (paddr == rxs_pkg::RXS_SYMBOL_ERROR_COUNT_ADDR);
    wire sel_rxerr  = (paddr == rxs_pkg::RXS_RECEIVE_ERROR_COUNT_ADDR);
    wire sel_status = (paddr == rxs_pkg::RXS_INT_STATUS_ADDR);
    wire sel_mask   = (paddr == rxs_pkg::RXS_INT_MASK_ADDR);
    wire sel_ctrl   = (paddr == rxs_pkg::RXS_CONTROL_ADDR);

    wire [rxs_pkg::RXS_NUM_CNT-1:0] sel_cnt = {sel_rxerr, sel_sym, sel_align, sel_crc};
    wire sel_any = (|sel_cnt) || sel_status || sel_mask || sel_ctrl;

    // counters are read-only: a write to one is refused
    wire bad_access = !sel_any || (pwrite && (|sel_cnt));

    // read of a counter clears it
    wire [rxs_pkg::RXS_NUM_CNT-1:0] rd_clear = sel_cnt & {rxs_pkg::RXS_NUM_CNT{apb_rd}};

    wire [31:0] rd_data =
        sel_crc    ? cnt_r[rxs_pkg::RXS_IDX_CRC]   :
        sel_align  ? cnt_r[rxs_pkg::RXS_IDX_ALIGN] :
        sel_sym    ? cnt_r[rxs_pkg::RXS_IDX_SYM]   :
        sel_rxerr  ? cnt_r[rxs_pkg::RXS_IDX_RXERR] :
        sel_status ? {28'h0000000, int_status_r}   :
        sel_mask   ? {28'h0000000, int_mask_r}     :
        sel_ctrl   ? {30'h0000000, ctrl_r}         :
                     rxs_pkg::RXS_DATA_ZERO;

    // ----------------------------------------
    // event qualification
    // ----------------------------------------
    wire rx_enable  = ctrl_r[rxs_pkg::RXS_CTRL_RX_ENABLE];
    wire serdes_on  = ctrl_r[rxs_pkg::RXS_CTRL_SERDES];
    wire mii_speed  = (link_speed == rxs_pkg::RXS_SPEED_10) || (link_speed == rxs_pkg::RXS_SPEED_100);

    // frame is counted once filtered and stored, no host transfer needed
    wire frame_ok   = rx_frame.done && rx_frame.filter_pass
                      && (rx_frame.length >= rxs_pkg::RXS_MIN_FRAME);

    wire ev_crc     = rx_enable && frame_ok && rx_frame.crc_bad;
    wire ev_align   = rx_enable && frame_ok && rx_frame.align_bad
                      && !serdes_on && mii_speed;
    wire ev_sym     = serdes_on && serdes_evt.bad_symbol;
    wire ev_rxerr   = rx_enable && (serdes_on ? serdes_evt.invalid_code
                      : (frame_ok && rx_frame.phy_receive_error_flag));

    wire [rxs_pkg::RXS_NUM_CNT-1:0] ev_vec = {ev_rxerr, ev_sym, ev_align, ev_crc};

    // ----------------------------------------
    // counters
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < rxs_pkg::RXS_NUM_CNT; gi++) begin : g_cnt
            logic [rxs_pkg::RXS_CNT_W-1:0] cnt_nxt;
            wire   at_max = (cnt_r[gi] == rxs_pkg::RXS_CNT_MAX);

            // clear with coincident event leaves one, saturate at all-ones
            assign cnt_nxt = rd_clear[gi] ? (ev_vec[gi] ? rxs_pkg::RXS_CNT_ONE : rxs_pkg::RXS_CNT_RESET)
                           : (ev_vec[gi] && !at_max) ? cnt_r[gi] + rxs_pkg::RXS_CNT_ONE
                           : cnt_r[gi];

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r[gi] <= rxs_pkg::RXS_CNT_RESET;
                end else begin
                    cnt_r[gi] <= cnt_nxt;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // interrupt status, mask, control
    // ----------------------------------------
    wire [rxs_pkg::RXS_NUM_CNT-1:0] w1c = (apb_wr && sel_status) ? pwdata[rxs_pkg::RXS_NUM_CNT-1:0]
                                                                  : {rxs_pkg::RXS_NUM_CNT{1'b0}};
    // set wins over a same-cycle clear
    wire [rxs_pkg::RXS_NUM_CNT-1:0] int_status_nxt = (int_status_r & ~w1c) | ev_vec;
    wire [rxs_pkg::RXS_NUM_CNT-1:0] int_mask_nxt   = (apb_wr && sel_mask) ? pwdata[rxs_pkg::RXS_NUM_CNT-1:0]
                                                                           : int_mask_r;
    wire [1:0] ctrl_nxt = (apb_wr && sel_ctrl) ? pwdata[1:0] : ctrl_r;
    wire       irq_nxt  = |(int_status_nxt & int_mask_nxt);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_status_r <= rxs_pkg::RXS_MASK_RESET;
            int_mask_r   <= rxs_pkg::RXS_MASK_RESET;
            ctrl_r       <= rxs_pkg::RXS_CTRL_RESET;
            irq          <= 1'b0;
        end else begin
            int_status_r <= int_status_nxt;
            int_mask_r   <= int_mask_nxt;
            ctrl_r       <= ctrl_nxt;
            irq          <= irq_nxt;
        end
    end

    // ----------------------------------------
    // apb response registers
    // ----------------------------------------
    // pready/prdata registered: answer one cycle after the setup cycle
    wire        pready_nxt  = psel && !penable;
    wire        pslverr_nxt = psel && !penable && bad_access;
    wire [31:0] prdata_nxt  = apb_rd ? rd_data : rxs_pkg::RXS_DATA_ZERO;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= rxs_pkg::RXS_DATA_ZERO;
        end else begin
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata  <= prdata_nxt;
        end
    end

endmodule

`default_nettype wire

/* test/rxs_mac_model.sv */
// receive mac path model: frame reports and serdes pulses
`timescale 1ns/1ps
`default_nettype none
module rxs_mac_model (
    input  wire logic                clk_sys,
    output var rxs_pkg::rxs_frame_t  rx_frame,
    output var rxs_pkg::rxs_serdes_t serdes_evt
);
    initial begin
        rx_frame   = '0;
        serdes_evt = '0;
    end
    // one stored frame per pulse; fields scrambled when idle
    task automatic send(input rxs_pkg::rxs_frame_t f, input rxs_pkg::rxs_serdes_t s);
        @(posedge clk_sys);
        rx_frame   <= f;
        serdes_evt <= s;
        @(posedge clk_sys);
        rx_frame   <= {1'b0, ~f[19:0]};
        serdes_evt <= 2'h0;
    endtask
endmodule
`default_nettype wire

/* test/rxs_stat_bank_checker.sv */
// checker: port-level assertions for the rx error statistics bank
`timescale 1ns/1ps
`default_nettype none
module rxs_stat_bank_checker (
    input wire logic                 clk_sys,
    input wire logic                 nrst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [15:0]          paddr,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire rxs_pkg::rxs_frame_t  rx_frame,
    input wire rxs_pkg::rxs_serdes_t serdes_evt,
    input wire logic                 irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic ctr = paddr[15:4] == 12'h400 && paddr[1:0] == 2'h0;
    wire logic mapped = ctr || paddr == rxs_pkg::RXS_INT_STATUS_ADDR
        || paddr == rxs_pkg::RXS_INT_MASK_ADDR || paddr == rxs_pkg::RXS_CONTROL_ADDR;
    wire logic wr_acc = psel && penable && pwrite;
    wire logic evt = rx_frame.done || serdes_evt != 2'h0;
    setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
    unmapped_err_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped not refused");
    counter_write_a: assert property (pready && pwrite && ctr |-> pslverr) else $error("counter write taken");
    mapped_read_a: assert property (pready && !pwrite && mapped |-> !pslverr) else $error("read refused");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc)) else $error("irq fell without write");
    irq_rise_a: assert property ($rose(irq) |-> $past(evt || wr_acc)) else $error("irq rose without cause");
endmodule
`default_nettype wire

/* test/rxs_stat_bank_tb.sv */
// testbench: rx error statistics bank
`timescale 1ns/1ps
`default_nettype none
module rxs_stat_bank_tb;
    logic                 clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [15:0]          paddr;
    logic [31:0]          pwdata, prdata, q, ex [4];
    logic [7:0]           r;
    logic [3:0]           h, st;
    rxs_pkg::rxs_frame_t  f, rx_frame;
    rxs_pkg::rxs_serdes_t s, serdes_evt;
    rxs_pkg::rxs_speed_t  link_speed, sp;
    int                   fail_count, checked;
    rxs_stat_bank i_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .rx_frame, .serdes_evt, .link_speed, .irq);
    rxs_mac_model i_mac (.clk_sys, .rx_frame, .serdes_evt);
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [15:0] ca(input int i);
        return rxs_pkg::RXS_CRC_ERROR_COUNT_ADDR + 16'(4 * i);
    endfunction
    function automatic logic [3:0] hits(input rxs_pkg::rxs_frame_t x, input rxs_pkg::rxs_serdes_t y,
                                        input rxs_pkg::rxs_speed_t v, input logic [1:0] c);
        logic ok;
        ok = x.done && x.filter_pass && x.length >= rxs_pkg::RXS_MIN_FRAME && c[0];
        return {c[0] && (c[1] ? y.invalid_code : ok && x.phy_receive_error_flag), y.bad_symbol && c[1],
                ok && x.align_bad && !c[1] && v != rxs_pkg::RXS_SPEED_1000, ok && x.crc_bad};
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            fail_count++;
            print_verdict;
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, fail_count, checked, st} = '0;
        link_speed = rxs_pkg::RXS_SPEED_10;
        r = 8'h50;
        repeat (4) @(posedge clk_sys);
        nrst <= 1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            apb(0, ca(i), 0);
            chk("reset", q, 0);
            ex[i] = 0;
        end
        apb(1, rxs_pkg::RXS_INT_MASK_ADDR, 32'h0000_000F);
        for (int m = 0; m < 4; m++) begin
            apb(1, rxs_pkg::RXS_CONTROL_ADDR, 32'(m));
            for (int k = 0; k < 16; k++) begin
                r = lfsr(r);
                f = {1'b1, 16'h003C + 16'(r[2:0]), r[6:3]};
                r = lfsr(r);
                s = r[1:0];
                sp = r[2] ? rxs_pkg::RXS_SPEED_1000 : rxs_pkg::rxs_speed_t'({1'b0, r[3]});
                link_speed <= sp;
                h = hits(f, s, sp, 2'(m));
                st = st | h;
                i_mac.send(f, s);
                for (int i = 0; i < 4; i++) ex[i] += 32'(h[i]);
            end
            for (int i = 0; i < 4; i++) begin
                apb(0, ca(i), 0);
                chk("count", q, ex[i]);
                apb(0, ca(i), 0);
                chk("clear", q, 0);
                ex[i] = 0;
            end
            chk("irq", irq, 32'(|st));
        end
        apb(0, rxs_pkg::RXS_INT_STATUS_ADDR, 0);
        chk("status", q, 32'(st));
        apb(1, rxs_pkg::RXS_INT_STATUS_ADDR, 32'h0000_000F);
        apb(1, rxs_pkg::RXS_INT_MASK_ADDR, 0);
        apb(1, rxs_pkg::RXS_CONTROL_ADDR, 1);
        f = {1'b1, 16'h0040, 4'hC};
        i_mac.send(f, 2'h0);
        apb(0, rxs_pkg::RXS_INT_STATUS_ADDR, 0);
        chk("status", q, 1);
        chk("masked irq", irq, 0);
        apb(0, ca(0), 0);
        chk("boundary", q, 1);
        fork
            apb(0, ca(0), 0);
            i_mac.send(f, 2'h0);
        join
        chk("race old", q, 0);
        apb(0, ca(0), 0);
        chk("race kept", q, 1);
        apb(0, 16'h4010, 0);
        chk("unmapped", e, 1);
        apb(1, ca(0), 32'h0000_1234);
        chk("wr refused", e, 1);
        apb(0, ca(0), 0);
        chk("wr ignored", q, 0);
        print_verdict;
    end
endmodule
bind rxs_stat_bank rxs_stat_bank_checker i_chk (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .paddr, .pready, .prdata, .pslverr, .rx_frame, .serdes_evt, .irq);
`default_nettype wire
